// File: acsd_consts.vh
// constants for the sample clock divider block: register map, fields, reset values, timing
// Functional notes
// - the sampling clock comes from the nyquist input or the rf input, chosen by a register, nyquist after reset.
// - with the rf input chosen, its clock is first divided by a fixed four in a predivider.
// - a programmable integer divider with ratios 1 to 8 follows, set by its own register and shared by both paths.
// - any ratio other than one turns the duty cycle stabilizer on, whatever its own enable says.
// - two bits of the resync register choose resync on every sysref or only on the first one after a write.
// - a qualifying sysref returns the divider count to its initial state so several parts sample together.
// - with the stabilizer active and locked the falling edge is regenerated at half period; the rising edge stays.
// - the stabilizer loop does not work for slow clocks; there the output keeps the raw divided duty cycle (the input duty at ratio one).
// - while the loop is unlocked the stabilizer is bypassed and the raw duty cycle passes through.
// - each sample is taken at the rising edge of the internal divided clock.
`ifndef ACSD_CONSTS_VH
`define ACSD_CONSTS_VH

// register indices; byte address is four times the index
`define ACSD_IDX_DIV_RATIO   8'h08
`define ACSD_IDX_CLK_SRC     8'h09
`define ACSD_IDX_RESYNC      8'h3a
`define ACSD_IDX_STATUS      8'h40

// field positions
`define ACSD_DIV_LSB         0
`define ACSD_DIV_MSB         2
`define ACSD_SRC_RF_BIT      0
`define ACSD_SRC_DCS_EN_BIT  1
`define ACSD_RS_EVERY_BIT    1
`define ACSD_RS_FIRST_BIT    2

// reset values
`define ACSD_DIV_RST         3'h0
`define ACSD_SRC_RST         2'h2
`define ACSD_RS_RST          2'h0

// fixed rf predivider last count (divide by four)
`define ACSD_PREDIV_LAST     2'h3

// axi responses
`define ACSD_RESP_OKAY       2'h0
`define ACSD_RESP_SLVERR     2'h2

// stabilizer loop: periods to lock, largest period in aclk cycles it can handle
`define ACSD_LOCK_PERIODS    4
`define ACSD_LOOP_MAX_PERIOD 32

`endif

// File: acsd_top.v
// sample clock source select, rf predivider, 1 to 8 divider, sysref resync and duty cycle stabilizer
`timescale 1ns/1ps
`include "acsd_consts.vh"

module acsd_top #(
	parameter LOCK_PERIODS    = `ACSD_LOCK_PERIODS,
	parameter LOOP_MAX_PERIOD = `ACSD_LOOP_MAX_PERIOD
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address and data
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// clock pins and sysref, asynchronous to aclk
	input  wire        nyquist_clk_in,
	input  wire        high_frequency_clock_input,
	input  wire        sysref_in,
	// internal sampling clock
	output reg         sample_clk_q,
	output reg         sample_strobe_q,
	output reg         dcs_locked_q
);

	// register state
	reg  [2:0]  div_ratio_q;
	reg  [1:0]  clk_src_q;
	reg  [1:0]  resync_q;
	reg         oneshot_armed_q;

	// synchronisers: bit 0 nyquist pin, bit 1 rf pin, bit 2 sysref
	reg  [2:0]  sync1_q;
	reg  [2:0]  sync2_q;
	reg  [2:0]  sync3_q;

	// divider state
	reg  [1:0]  prediv_q;
	reg         prediv_lvl_q;
	reg  [2:0]  div_cnt_q;
	reg         raw_div_q;

	// stabilizer state
	reg  [7:0]  period_cnt_q;
	reg  [7:0]  last_period_q;
	reg  [3:0]  match_cnt_q;
	reg         dcs_lvl_q;

	// helper combinational signals
	wire        nyq_rise;
	wire        nyq_fall;
	wire        rf_rise;
	wire        sysref_rise;
	wire        prediv_rise;
	wire        src_rise;
	wire        src_lvl;
	wire        resync_hit;
	wire        div_rise;
	wire        dcs_on;
	wire        loop_ok;
	wire        dcs_active;
	wire [2:0]  half_cnt;
	wire [7:0]  half_period;
	wire [7:0]  period_diff;
	wire        wr_fire;
	wire        rd_fire;
	wire [7:0]  wr_idx;
	wire [7:0]  rd_idx;
	wire        wr_hit;
	reg  [31:0] rd_data;
	reg         rd_hit;
	reg         raw_div_d;
	reg         sample_clk_d;

	// edges come from the second and third flops only; the first is metastability guard
	assign nyq_rise    = sync2_q[0] & ~sync3_q[0];
	assign nyq_fall    = ~sync2_q[0] & sync3_q[0];
	assign rf_rise     = sync2_q[1] & ~sync3_q[1];
	assign sysref_rise = sync2_q[2] & ~sync3_q[2];

	// fixed divide by four on the rf path
	assign prediv_rise = rf_rise && (prediv_q == `ACSD_PREDIV_LAST);

	// source select, nyquist after reset
	assign src_rise = clk_src_q[`ACSD_SRC_RF_BIT] ? prediv_rise : nyq_rise;
	assign src_lvl  = clk_src_q[`ACSD_SRC_RF_BIT] ? prediv_lvl_q : sync2_q[0];

	// sysref qualifies always in every mode, or once while armed in first mode
	assign resync_hit = sysref_rise &&
		(resync_q[0] || (resync_q[1] && oneshot_armed_q));

	// divided rising edge at count wrap; ratio field holds ratio minus one
	assign div_rise = src_rise && (div_cnt_q == div_ratio_q) && !resync_hit;
	assign half_cnt = {1'b0, div_ratio_q[2:1]} + {2'b00, div_ratio_q[0]};

	// stabilizer forced on for any ratio other than one
	assign dcs_on      = clk_src_q[`ACSD_SRC_DCS_EN_BIT] || (div_ratio_q != 3'h0);
	assign loop_ok     = (last_period_q != 8'h00) && (last_period_q <= LOOP_MAX_PERIOD);
	assign dcs_active  = dcs_on && dcs_locked_q && loop_ok;
	assign half_period = {1'b0, last_period_q[7:1]};
	assign period_diff = (period_cnt_q > last_period_q) ? (period_cnt_q - last_period_q)
		: (last_period_q - period_cnt_q);

	// bus decode
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign wr_idx  = s_axi_awaddr[9:2];
	assign rd_idx  = s_axi_araddr[9:2];
	assign wr_hit  = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[31:10] == 22'h000000) &&
		((wr_idx == `ACSD_IDX_DIV_RATIO) || (wr_idx == `ACSD_IDX_CLK_SRC) ||
		(wr_idx == `ACSD_IDX_RESYNC) || (wr_idx == `ACSD_IDX_STATUS));

	// read mux; narrow registers sit in the low bits, resync at bits 2 and 1
	always @* begin
		rd_data = 32'h00000000;
		rd_hit  = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:10] == 22'h000000);
		case (rd_idx)
			`ACSD_IDX_DIV_RATIO: rd_data[2:0] = div_ratio_q;
			`ACSD_IDX_CLK_SRC:   rd_data[1:0] = clk_src_q;
			`ACSD_IDX_RESYNC:    rd_data[2:1] = resync_q;
			`ACSD_IDX_STATUS:    rd_data[3:0] = {oneshot_armed_q, sample_clk_q, dcs_active, dcs_locked_q};
			default:             rd_hit       = 1'b0;
		endcase
	end

	// raw divided clock: ratio one passes the source duty, else high for half the count
	always @* begin
		raw_div_d = raw_div_q;
		if (resync_hit) begin
			raw_div_d = 1'b0;
		end else if (div_rise) begin
			raw_div_d = 1'b1;
		end else if (div_ratio_q == 3'h0) begin
			raw_div_d = src_lvl;
		end else if (src_rise && (div_cnt_q == half_cnt - 3'h1)) begin
			raw_div_d = 1'b0;
		end
	end

	// output clock: rises only at a divided edge, so every rise has its strobe
	always @* begin
		if (!sample_clk_q) begin
			sample_clk_d = div_rise;
		end else if (div_rise) begin
			sample_clk_d = 1'b0; // a high still standing after a period shortened is dropped, the next rise is clean
		end else if (dcs_active) begin
			sample_clk_d = dcs_lvl_q;
		end else begin
			sample_clk_d = raw_div_d;
		end
	end

	// pin synchronisers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {sysref_in, high_frequency_clock_input, nyquist_clk_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// register writes; a write to the resync register re-arms the one-shot
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_ratio_q     <= `ACSD_DIV_RST;
			clk_src_q       <= `ACSD_SRC_RST;
			resync_q        <= `ACSD_RS_RST;
			oneshot_armed_q <= 1'b0;
		end else begin
			if (wr_fire && wr_hit && s_axi_wstrb[0] && (wr_idx == `ACSD_IDX_DIV_RATIO)) begin
				div_ratio_q <= s_axi_wdata[`ACSD_DIV_MSB:`ACSD_DIV_LSB];
			end
			if (wr_fire && wr_hit && s_axi_wstrb[0] && (wr_idx == `ACSD_IDX_CLK_SRC)) begin
				clk_src_q <= s_axi_wdata[1:0];
			end
			// a sysref that lands with the write is consumed before the re-arm takes over
			if (wr_fire && wr_hit && s_axi_wstrb[0] && (wr_idx == `ACSD_IDX_RESYNC)) begin
				resync_q        <= {s_axi_wdata[`ACSD_RS_FIRST_BIT], s_axi_wdata[`ACSD_RS_EVERY_BIT]};
				oneshot_armed_q <= 1'b1;
			end else if (resync_hit) begin
				oneshot_armed_q <= 1'b0;
			end
		end
	end

	// axi write channel: address and data taken together, response the next cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ACSD_RESP_OKAY;
		end else begin
			s_axi_awready <= wr_fire;
			s_axi_wready  <= wr_fire;
			if (wr_fire) begin
				s_axi_bresp <= wr_hit ? `ACSD_RESP_OKAY : `ACSD_RESP_SLVERR;
			end
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ACSD_RESP_OKAY;
		end else begin
			s_axi_arready <= rd_fire;
			if (rd_fire) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_hit ? `ACSD_RESP_OKAY : `ACSD_RESP_SLVERR;
			end
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// predivider and divider counters; resync puts both at their initial state
	always @(posedge aclk) begin
		if (!aresetn) begin
			prediv_q     <= 2'h0;
			prediv_lvl_q <= 1'b0;
			div_cnt_q    <= 3'h0;
			raw_div_q    <= 1'b0;
		end else begin
			raw_div_q <= raw_div_d;
			if (resync_hit) begin
				prediv_q     <= 2'h0;
				prediv_lvl_q <= 1'b0;
				div_cnt_q    <= 3'h0;
			end else begin
				if (rf_rise) begin
					prediv_q     <= prediv_q + 2'h1;
					prediv_lvl_q <= (prediv_q == `ACSD_PREDIV_LAST) || (prediv_q == 2'h0);
				end
				if (src_rise) begin
					div_cnt_q <= (div_cnt_q >= div_ratio_q) ? 3'h0 : div_cnt_q + 3'h1;
				end
			end
		end
	end

	// period measure and lock: lock after a run of stable periods, drop on a jump of more than one cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			period_cnt_q  <= 8'h00;
			last_period_q <= 8'h00;
			match_cnt_q   <= 4'h0;
			dcs_locked_q  <= 1'b0;
		end else if (div_rise) begin
			period_cnt_q  <= 8'h01;
			last_period_q <= period_cnt_q;
			// a period beyond the loop limit never counts towards lock
			if ((period_diff <= 8'h01) && (period_cnt_q <= LOOP_MAX_PERIOD)) begin
				if (match_cnt_q < LOCK_PERIODS) begin
					match_cnt_q <= match_cnt_q + 4'h1;
				end
				dcs_locked_q <= (match_cnt_q >= LOCK_PERIODS - 1);
			end else begin
				match_cnt_q  <= 4'h0; // frequency moved, loop relocks
				dcs_locked_q <= 1'b0;
			end
		end else if (period_cnt_q != 8'hff) begin
			period_cnt_q <= period_cnt_q + 8'h01;
		end else begin
			match_cnt_q  <= 4'h0; // clock stopped or too slow for the loop
			dcs_locked_q <= 1'b0;
		end
	end

	// regenerated half-period level and the sample outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			dcs_lvl_q       <= 1'b0;
			sample_clk_q    <= 1'b0;
			sample_strobe_q <= 1'b0;
		end else begin
			if (div_rise) begin
				dcs_lvl_q <= 1'b1;
			end else if (period_cnt_q >= half_period - 8'h01) begin
				dcs_lvl_q <= 1'b0; // one early: the output flop adds a cycle
			end
			sample_clk_q    <= sample_clk_d;
			sample_strobe_q <= div_rise && !sample_clk_q;
		end
	end

endmodule

// File: acsd_top_monitor.sv
// assertion checker watching the sample clock divider top ports
`timescale 1ns/1ps
module acsd_monitor (
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// bus handshakes
	input logic        s_axi_awready,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	// sampling clock
	input logic        sample_clk_q,
	input logic        sample_strobe_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// the sample instant marks each rising edge, no other cycle
	property p_strobe_rise;
		sample_strobe_q == $rose(sample_clk_q);
	endproperty
	a_strobe_rise:
	assert property (p_strobe_rise) else $error("strobe and sampling clock rise disagree");
	property p_aw_w;
		s_axi_awready == s_axi_wready;
	endproperty
	a_aw_w: assert property (p_aw_w) else $error("address and data taken apart");
	property p_aw_b;
		s_axi_awready |=> s_axi_bvalid;
	endproperty
	a_aw_b: assert property (p_aw_b) else $error("write response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response not cleared");
	// a new write must wait for the old response to go
	property p_no_aw;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_no_aw: assert property (p_no_aw) else $error("write taken during response");
	property p_bcode;
		s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2};
	endproperty
	a_bcode: assert property (p_bcode) else $error("bad write response code");
	property p_ar_r;
		s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_r: assert property (p_ar_r) else $error("read data late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule

bind acsd_top acsd_monitor i_acsd_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_clk_q,
	.sample_strobe_q);

// File: acsd_clk_src_model.sv
// clock source and sysref generator facing the sampling clock pins
`timescale 1ns/1ps
module acsd_clk_src_model (
	// half periods in aclk cycles, zero parks a clock low
	input wire [7:0] nyq_half,
	input wire [7:0] rf_half,
	input wire       sysref_req,
	// pins
	output logic     nyq_clk = 1'b0,
	output logic     rf_clk = 1'b0,
	output logic     sysref = 1'b0
);
	// toggles land on aclk falling edges, away from the sampling edge
	always begin
		#(nyq_half == 0 ? 50 : nyq_half * 50);
		nyq_clk = nyq_half != 0 ? ~nyq_clk : 1'b0;
	end
	always begin
		#(rf_half == 0 ? 50 : rf_half * 50);
		rf_clk = rf_half != 0 ? ~rf_clk : 1'b0;
	end
	// sysref held four aclk so the synchroniser cannot miss it
	always @(posedge sysref_req) begin
		#7 sysref = 1'b1;
		#200 sysref = 1'b0;
	end
endmodule

// File: adc_sample_clock_divider_tb.sv
// self-checking bench for the sample clock divider
`timescale 1ns/1ps
`define CHK(nm, e, s) cmp_count++; if ((s) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", nm, e, s); end
`define WAIT(c) n = 0; while (!(c)) begin @(posedge aclk); n++; if (n > 4000) begin error_cnt++; print_verdict(); end end
module adc_sample_clock_divider_tb;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sreq = 0;
	logic [31:0] awa = 0, wd = 0, ara = 0;
	logic [7:0]  nh = 2, rh = 0;
	wire         awr, wr, bv, arr, rv, nyq, rfc, sref, sclk, stb, lck;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	int          error_cnt = 0, cmp_count = 0, n, p, h, l;

	always #25 aclk = ~aclk;

	acsd_top i_acsd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.nyquist_clk_in(nyq), .high_frequency_clock_input(rfc), .sysref_in(sref), .sample_clk_q(sclk),
		.sample_strobe_q(stb), .dcs_locked_q(lck));
	acsd_clk_src_model i_acsd_clk_src_model (.nyq_half(nh), .rf_half(rh), .sysref_req(sreq), .nyq_clk(nyq),
		.rf_clk(rfc), .sysref(sref));

	// bus write and read; a spare edge at the end avoids double drives
	task automatic wr_reg(input logic [31:0] a, d, input logic [1:0] e);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		`WAIT(awr && wr)
		awv <= 1'b0;
		wv <= 1'b0;
		`WAIT(bv)
		bry <= 1'b0;
		`CHK("bresp", e, br)
		@(posedge aclk);
	endtask
	task automatic rd_reg(input logic [31:0] a, e, m, input logic [1:0] er);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		`WAIT(arr)
		arv <= 1'b0;
		`WAIT(rv)
		rry <= 1'b0;
		`CHK("rdata", e, rdat & m)
		`CHK("rresp", er, rr)
		@(posedge aclk);
	endtask
	// cycles between rises and cycles high, measured from one rise
	task automatic meas();
		`WAIT(!sclk)
		`WAIT(sclk)
		p = 1;
		h = 1;
		l = 1;
		while (p < 300) begin
			@(posedge aclk);
			if (sclk && !l)
				break;
			h += sclk;
			l = sclk;
			p++;
		end
	endtask
	task automatic t_regs();
		rd_reg(32'h20, 0, 32'h7, 2'h0);
		rd_reg(32'h24, 2, 32'h3, 2'h0);
		rd_reg(32'he8, 0, 32'h6, 2'h0);
		rd_reg(32'h10, 0, 32'hffffffff, 2'h2);
		wr_reg(32'h10, 1, 2'h2);
		meas();
		`CHK("nyq period", 4, p)
	endtask
	task automatic t_ratio();
		for (int r = 1; r <= 8; r++) begin
			wr_reg(32'h20, r - 1, 2'h0);
			rd_reg(32'h20, r - 1, 32'h7, 2'h0);
			meas();
			meas();
			`CHK("div period", 4 * r, p)
		end
	endtask
	task automatic t_rf();
		rh <= 2;
		wr_reg(32'h24, 3, 2'h0);
		for (int r = 1; r <= 2; r++) begin
			wr_reg(32'h20, r - 1, 2'h0);
			meas();
			meas();
			`CHK("rf period", 16 * r, p)
		end
		wr_reg(32'h24, 2, 2'h0);
		rh <= 0;
	endtask
	// stabilizer enable cleared, ratio three must still force it on
	task automatic t_dcs();
		wr_reg(32'h24, 0, 2'h0);
		wr_reg(32'h20, 2, 2'h0);
		repeat (8) meas();
		`CHK("dcs period", 12, p)
		`CHK("dcs high", 6, h)
		`CHK("locked", 1'b1, lck)
		wr_reg(32'h24, 2, 2'h0);
	endtask
	task automatic t_slow();
		wr_reg(32'h20, 0, 2'h0);
		nh <= 20;
		repeat (4) meas();
		`CHK("slow period", 40, p)
		`CHK("slow high", 20, h)
		`CHK("unlocked", 1'b0, lck)
		nh <= 2;
	endtask
	// strobe to strobe in aclk cycles, sysref raised one cycle after the first strobe
	task automatic sysref_gap();
		`WAIT(stb)
		@(posedge aclk);
		sreq <= 1'b1;
		p = 1;
		do begin
			@(posedge aclk);
			p++;
		end while (!stb && p < 300);
		sreq <= 1'b0;
	endtask
	// ratio eight: 32 cycles between strobes, 36 when a sysref restarts the count
	task automatic t_resync();
		wr_reg(32'h20, 7, 2'h0);
		wr_reg(32'he8, 4, 2'h0);
		rd_reg(32'h100, 8, 32'h8, 2'h0);
		sysref_gap();
		`CHK("first sysref gap", 36, p)
		rd_reg(32'h100, 0, 32'h8, 2'h0);
		sysref_gap();
		`CHK("later sysref gap", 32, p)
		wr_reg(32'he8, 2, 2'h0);
		rd_reg(32'he8, 2, 32'h6, 2'h0);
		repeat (2) begin
			sysref_gap();
			`CHK("every sysref gap", 36, p)
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_ratio();
		t_rf();
		t_dcs();
		t_slow();
		t_resync();
		print_verdict();
	end
endmodule
